// ===== rtl/rft_frame_tx.sv
// Functional notes
// - each result goes out as one serial frame starting with header 0xaa.
// - distance follows header as 16-bit centimetres, low byte first.
// - one gesture byte then trailer 0x55; frame is five bytes.
// - gesture byte is 0x00 for none and 0x01 for recognised.
// - recognised gesture appears in a frame about a quarter second later.
// - gesture flag set only when distance lies within configurable range.
// - frames emitted once per reporting period of fifty milliseconds.
`timescale 1ns/100ps
module rft_frame_tx
  import rft_pkg::*;
#(
  parameter int unsigned PERIOD  = PERIOD_CYC,
  parameter int unsigned GEST_LAT = GEST_LAT_CYC
)
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [15:0] DIST_CM,
  input  wire logic        GEST_EVT,
  input  wire logic [15:0] RANGE_CM,
  output      logic        TXD,
  output      logic        BUSY
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } rft_state_e;

  rft_state_e       state_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] lat_q;
  logic             lat_run_q;
  logic             gest_q;
  logic [15:0]      dist_q;
  logic [2:0]       idx_q;
  logic [7:0]       byte_d;
  logic             tx_ready;
  logic             tx_valid;
  logic             tick;

  function automatic logic [7:0] frame_byte(input logic [2:0] i,
                                            input logic [15:0] d,
                                            input logic g);
    case (i)
      3'h0:    frame_byte = HDR_BYTE;
      3'h1:    frame_byte = d[7:0];
      3'h2:    frame_byte = d[15:8];
      3'h3:    frame_byte = g ? GEST_SEEN : GEST_NONE;
      default: frame_byte = TRL_BYTE;
    endcase
  endfunction

  assign tick = (per_q == PERIOD - 1);

  // reporting period counter
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      per_q <= '0;
    else if (tick)
      per_q <= '0;
    else
      per_q <= per_q + 1'b1;
  end

  // gesture latency: in-range event surfaces after the pipeline delay
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      lat_q     <= '0;
      lat_run_q <= 1'b0;
      gest_q    <= 1'b0;
    end
    else
    begin
      if (GEST_EVT && DIST_CM <= RANGE_CM && !lat_run_q)
      begin
        lat_run_q <= 1'b1;
        lat_q     <= '0;
      end
      else if (lat_run_q && lat_q == GEST_LAT - 1)
      begin
        lat_run_q <= 1'b0;
        gest_q    <= 1'b1;
      end
      else if (lat_run_q)
        lat_q <= lat_q + 1'b1;
      if (state_q == ST_IDLE && tick && !(lat_run_q && lat_q == GEST_LAT - 1))
        gest_q <= 1'b0;
    end
  end

  // frame sequencer
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      idx_q   <= 3'h0;
      dist_q  <= 16'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (tick)
          begin
            state_q <= ST_SEND;
            idx_q   <= 3'h0;
            dist_q  <= DIST_CM;
          end
        ST_SEND:
          if (tx_ready)
          begin
            if (idx_q == 3'(FRAME_LEN - 1))
              state_q <= ST_IDLE;
            else
              idx_q <= idx_q + 3'h1;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  logic gest_frame_q;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      gest_frame_q <= 1'b0;
    else if (state_q == ST_IDLE && tick)
      gest_frame_q <= gest_q;
  end

  assign byte_d   = frame_byte(idx_q, dist_q, gest_frame_q);
  assign tx_valid = (state_q == ST_SEND);
  assign BUSY     = (state_q == ST_SEND) || !tx_ready;

  rft_uart_tx u_tx (
    .clk   (CLK),
    .rst   (RST),
    .valid (tx_valid),
    .data  (byte_d),
    .ready (tx_ready),
    .txd   (TXD)
  );

  frame_start_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && tick) |=> (state_q == ST_SEND && idx_q == 3'h0))
    else $error("frame did not start on period tick");

  header_first_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && tx_ready && idx_q == 3'h0) |-> byte_d == 8'haa)
    else $error("header byte wrong");

  line_idle_a: assert property (@(posedge CLK) disable iff (RST)
    !BUSY |-> TXD)
    else $error("serial line not idle between frames");

  dist_order_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && tx_ready && idx_q == 3'h1) |-> byte_d == dist_q[7:0])
    else $error("distance low byte not first");

  dist_high_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && tx_ready && idx_q == 3'h2) |-> byte_d == dist_q[15:8])
    else $error("distance high byte not second");

  dist_latch_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && tick) |=> dist_q == $past(DIST_CM))
    else $error("distance not captured at frame start");

  trailer_last_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && tx_ready && idx_q == 3'h4) |=> state_q == ST_IDLE)
    else $error("frame not five bytes");

  busy_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && tx_ready && idx_q == 3'h4) |=> BUSY)
    else $error("busy dropped before trailer went out");

  trailer_val_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && idx_q == 3'h4) |-> byte_d == 8'h55)
    else $error("trailer byte wrong");

  gest_code_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && idx_q == 3'h3) |-> byte_d[7:1] == 7'h0)
    else $error("gesture byte not 0 or 1");

  gest_byte_a: assert property (@(posedge CLK) disable iff (RST)
    (tx_valid && idx_q == 3'h3) |-> byte_d[0] == gest_frame_q)
    else $error("gesture byte does not follow latched flag");

  range_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (GEST_EVT && DIST_CM > RANGE_CM && !lat_run_q) |=> !lat_run_q)
    else $error("out of range gesture accepted");

  range_accept_a: assert property (@(posedge CLK) disable iff (RST)
    (GEST_EVT && DIST_CM <= RANGE_CM && !lat_run_q) |=>
      (lat_run_q && lat_q == '0))
    else $error("in range gesture not accepted");

  lat_done_a: assert property (@(posedge CLK) disable iff (RST)
    (lat_run_q && lat_q == GEST_LAT - 1) |=> gest_q)
    else $error("gesture flag not raised after latency");

  gest_latch_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && tick) |=> gest_frame_q == $past(gest_q))
    else $error("gesture flag not carried into frame");

  gest_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && tick && !(lat_run_q && lat_q == GEST_LAT - 1))
      |=> !gest_q)
    else $error("gesture flag not cleared at frame start");

  frame_c: cover property (@(posedge CLK) disable iff (RST)
    tx_valid && tx_ready && idx_q == 3'h4);

  gest_c: cover property (@(posedge CLK) disable iff (RST)
    tx_valid && idx_q == 3'h3 && byte_d == 8'h01);

  range_c: cover property (@(posedge CLK) disable iff (RST)
    GEST_EVT && DIST_CM > RANGE_CM);

  done_c: cover property (@(posedge CLK) disable iff (RST)
    lat_run_q && lat_q == GEST_LAT - 1);
endmodule

// ===== pkg/rft_pkg.sv
package rft_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BAUD            = 115_200;
  localparam logic [15:0] BIT_CYC         = 16'(CLK_HZ / BAUD);
  localparam logic [7:0]  HDR_BYTE        = 8'haa;
  localparam logic [7:0]  TRL_BYTE        = 8'h55;
  localparam logic [7:0]  GEST_NONE       = 8'h00;
  localparam logic [7:0]  GEST_SEEN       = 8'h01;
  localparam int unsigned FRAME_LEN       = 5;
  localparam int unsigned PERIOD_MS       = 50;
  localparam int unsigned PERIOD_CYC      = PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned GEST_LAT_MS     = 250;
  localparam int unsigned GEST_LAT_CYC    = GEST_LAT_MS * (CLK_HZ / 1000);
  localparam logic [15:0] RANGE_CM_DFLT   = 16'd120;
  localparam int unsigned CNT_W           = 32;
endpackage

// ===== rtl/rft_uart_tx.sv
`timescale 1ns/100ps
module rft_uart_tx
  import rft_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output      logic       ready,
  output      logic       txd
);
  logic [9:0]  shift_q;
  logic [3:0]  bits_q;
  logic [15:0] cyc_q;

  assign ready = (bits_q == 4'h0);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_q <= 10'h3ff;
      bits_q  <= 4'h0;
      cyc_q   <= 16'h0;
    end
    else if (bits_q == 4'h0)
    begin
      if (valid)
      begin
        shift_q <= {1'b1, data, 1'b0};
        bits_q  <= 4'ha;
        cyc_q   <= BIT_CYC - 16'h1;
      end
    end
    else if (cyc_q == 16'h0)
    begin
      shift_q <= {1'b1, shift_q[9:1]};
      bits_q  <= bits_q - 4'h1;
      cyc_q   <= BIT_CYC - 16'h1;
    end
    else
      cyc_q <= cyc_q - 16'h1;
  end

  assign txd = shift_q[0];
endmodule

// ===== dv/rft_host_rx.sv
`timescale 1ns/100ps
module rft_host_rx
  import rft_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rxd,
  output      logic       got,
  output      logic [7:0] byte_q,
  output      logic       stop_ok
);
  // samples each bit mid-cell, one strobe per received byte
  initial
  begin
    got = 1'b0;
    byte_q = 8'h00;
    stop_ok = 1'b0;
    forever
    begin
      @(negedge rxd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        byte_q[i] = rxd;
      end
      repeat (BIT_CYC) @(posedge clk);
      stop_ok = rxd;
      got = 1'b1;
      @(posedge clk);
      got = 1'b0;
    end
  end
endmodule

// ===== dv/rft_frame_tx_tb_top.sv
`timescale 1ns/100ps
module rft_frame_tx_tb_top
  import rft_pkg::*;
;
  localparam int unsigned PER = 44000;
  logic        CLK;
  logic        RST;
  logic        TXD;
  logic        BUSY;
  logic        GEST_EVT;
  logic        got;
  logic        stop_ok;
  logic [15:0] DIST_CM;
  logic [15:0] RANGE_CM;
  logic [7:0]  rx_byte;
  logic [15:0] r;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t1;
  int          t2;
  int          exp_q[$];

  rft_frame_tx #(.PERIOD(PER), .GEST_LAT(100)) u_rft_frame_tx (
    .CLK(CLK), .RST(RST), .DIST_CM(DIST_CM), .GEST_EVT(GEST_EVT),
    .RANGE_CM(RANGE_CM), .TXD(TXD), .BUSY(BUSY));
  rft_host_rx u_rft_host_rx (.clk(CLK), .rxd(TXD), .got(got),
    .byte_q(rx_byte), .stop_ok(stop_ok));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 140000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // reference frame built from plain integers
  task automatic model(input int d, input int gest);
    exp_q = '{int'(HDR_BYTE), d % 256, d / 256, gest, int'(TRL_BYTE)};
  endtask

  task automatic rx_frame(output int t);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge got);
      if (i == 0)
        t = cyc;
      check(16'(rx_byte), 16'(exp_q.pop_front()));
      check(16'(stop_ok), 16'h0001);
      check(16'(BUSY), 16'h0001);
    end
    repeat (BIT_CYC) @(posedge CLK);
    check(16'(BUSY), 16'h0000);
  endtask

  initial
  begin
    RST = 1'b1;
    GEST_EVT = 1'b0;
    DIST_CM = 16'h0000;
    RANGE_CM = RANGE_CM_DFLT;
    void'($urandom(32'h251c79b0));
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    DIST_CM <= RANGE_CM_DFLT;
    // distance equal to the range still counts as inside
    repeat (PER - 400) @(posedge CLK);
    GEST_EVT <= 1'b1;
    @(posedge CLK);
    GEST_EVT <= 1'b0;
    model(int'(RANGE_CM_DFLT), 1);
    rx_frame(t1);
    r = 16'($urandom_range(32'h0fff, 32'h01ff));
    RANGE_CM <= r;
    DIST_CM <= r + 16'h0001;
    @(posedge CLK);
    GEST_EVT <= 1'b1;
    @(posedge CLK);
    GEST_EVT <= 1'b0;
    model(int'(r) + 1, 0);
    rx_frame(t2);
    check(16'(t2 - t1), 16'(PER));
    end_sim();
  end
endmodule
